/* core/cfd_fuse_decode.sv */
`timescale 1ns/1ps
// Operation
// - level field selects brown-out trip voltage
// - mode 11 forces brown-out on always
// - mode 10 on while awake, off asleep
// - mode 01 software control; 00 off
// - power-up timer enable bit active low
// - power-up timer independent of brown-out
// - watchdog postscale ratio is two to code
// - hard enable overrides software watchdog enable
// - reset pin select picks reset or input
// - fast start clocks CPU without waiting
// - debugger enabled when bit zero
// - extended CPU enabled when bit one
// - boot size bit sizes boot block
// - low voltage programming only when bit set
// - stack fault reset when bit set
// - code protect per region when zero
// - self-write block per region when zero
// - config write protect, program-mode only writable
// - table-read protect rejects foreign-block reads
// - protection bits clear-only except config write protect, unprogrammed one
// - unimplemented bits read zero
// - bytes mapped from 300000h, programmed reads zero
// - watchdog timeout is 4 ms times ratio
module cfd_fuse_decode
  import cfd_pkg::*;
#(
  parameter bit DEBUG_SILICON = 1'b0,
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        progMode,
  input  wire logic        cfgWrite,
  input  wire logic [21:0] cfgAddr,
  input  wire logic [7:0]  cfgWrData,
  input  wire logic        cfgRead,
  output logic      [7:0]  cfgRdData,
  input  wire logic        swBrownoutEnable,
  input  wire logic        sleepActive,
  input  wire logic        watchdogSoftEnable,
  input  wire logic        externalResetPin_n,
  input  wire logic        fastInternalOscStable,
  input  wire logic        stackFault,
  input  wire logic [1:0]  execBlock,
  input  wire logic [1:0]  readBlock,
  input  wire logic        tableRead,
  output logic [11:0]      brownoutTripVoltage,
  output logic             brownoutResetEnable,
  output logic             powerupDelayEnable,
  output logic [15:0]      watchdogPostscaleRatio,
  output logic [31:0]      watchdogTimeoutMs,
  output logic             watchdogEnable,
  output logic             externalResetActive,
  output logic             sharedInputPin,
  output logic             cpuClockEnable,
  output logic             debuggerEnable,
  output logic             extendedCpuEnable,
  output logic [11:0]      bootBlockWords,
  output logic             lowVoltProgEnable,
  output logic             stackFaultReset,
  output logic [3:0]       codeProtect,
  output logic [3:0]       selfWriteBlock,
  output logic             cfgWriteProtect,
  output logic             tableReadReject
);
  // non-volatile cells; not cleared by reset, start unprogrammed
  logic [7:0] borPwrCell  = CFD_RST_BORPWR;
  logic [7:0] wdogCell    = CFD_RST_WDOG;
  logic [7:0] rstOscCell  = CFD_RST_RSTOSC;
  logic [7:0] dbgCpuCell  = CFD_RST_DBGCPU;
  logic [7:0] blkCpCell   = CFD_RST_BLKLO;
  logic [7:0] bootCpCell  = CFD_RST_BOOTCP;
  logic [7:0] blkWpCell   = CFD_RST_BLKLO;
  logic [7:0] bootWpCell  = CFD_RST_BOOTWP;
  logic [7:0] blkTrpCell  = CFD_RST_BLKLO;
  logic [7:0] bootTrpCell = CFD_RST_BOOTTRP;
  // latched copies taken at reset
  logic [7:0] borPwr_r, wdog_r, rstOsc_r, dbgCpu_r;
  logic [7:0] blkCp_r, bootCp_r, blkWp_r, bootWp_r, blkTrp_r, bootTrp_r;
  logic       loaded_r;
  logic [3:0] idx;
  logic       inRange;
  logic       wrOk;

  assign idx     = cfgAddr[3:0];
  assign inRange = (cfgAddr[21:4] == CFD_BASE_ADDR[21:4]);
  // config bytes locked unless in program mode or write-protect bit set
  assign wrOk    = cfgWrite && inRange && (progMode || bootWpCell[CFD_POS_CFGWP]);

  // programming writes; protection cells only clear, except the config write-protect bit
  always_ff @(posedge mclk)
  begin
    if (wrOk)
    begin
      unique case (idx)
        CFD_IDX_BORPWR:  borPwrCell <= cfgWrData & CFD_MASK_BORPWR;
        CFD_IDX_WDOG:    wdogCell   <= cfgWrData & CFD_MASK_WDOG;
        CFD_IDX_RSTOSC:  rstOscCell <= cfgWrData & CFD_MASK_RSTOSC;
        CFD_IDX_DBGCPU:  dbgCpuCell <= (cfgWrData & CFD_MASK_DBGCPU)
                                       | (DEBUG_SILICON ? 8'h00 : CFD_DEBUG_BIT);
        CFD_IDX_BLKCP:   blkCpCell   <= blkCpCell & cfgWrData & CFD_MASK_BLKLO;
        CFD_IDX_BOOTCP:  bootCpCell  <= bootCpCell & cfgWrData & CFD_MASK_BOOTCP;
        CFD_IDX_BLKWP:   blkWpCell   <= blkWpCell & cfgWrData & CFD_MASK_BLKLO;
        CFD_IDX_BOOTWP:  bootWpCell  <= (bootWpCell & cfgWrData & CFD_CLRONLY_BOOTWP)
                                        | (progMode ? (cfgWrData & ~CFD_CLRONLY_BOOTWP
                                           & CFD_MASK_BOOTWP)
                                           : (bootWpCell & ~CFD_CLRONLY_BOOTWP));
        CFD_IDX_BLKTRP:  blkTrpCell  <= blkTrpCell & cfgWrData & CFD_MASK_BLKLO;
        CFD_IDX_BOOTTRP: bootTrpCell <= bootTrpCell & cfgWrData & CFD_MASK_BOOTTRP;
        default:         ;
      endcase
    end
  end

  // copy cells into decode registers while reset is held
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      borPwr_r  <= borPwrCell;
      wdog_r    <= wdogCell;
      rstOsc_r  <= rstOscCell;
      dbgCpu_r  <= dbgCpuCell;
      blkCp_r   <= blkCpCell;
      bootCp_r  <= bootCpCell;
      blkWp_r   <= blkWpCell;
      bootWp_r  <= bootWpCell;
      blkTrp_r  <= blkTrpCell;
      bootTrp_r <= bootTrpCell;
      loaded_r  <= 1'b0;
    end
    else
    begin
      loaded_r <= 1'b1;
    end
  end

  // readback of the cells; gaps and unimplemented bits read zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cfgRdData <= 8'h00;
    else if (cfgRead && inRange)
    begin
      unique case (idx)
        CFD_IDX_BORPWR:  cfgRdData <= borPwrCell & CFD_MASK_BORPWR;
        CFD_IDX_WDOG:    cfgRdData <= wdogCell & CFD_MASK_WDOG;
        CFD_IDX_RSTOSC:  cfgRdData <= rstOscCell & CFD_MASK_RSTOSC;
        CFD_IDX_DBGCPU:  cfgRdData <= dbgCpuCell & CFD_MASK_DBGCPU;
        CFD_IDX_BLKCP:   cfgRdData <= blkCpCell & CFD_MASK_BLKLO;
        CFD_IDX_BOOTCP:  cfgRdData <= bootCpCell & CFD_MASK_BOOTCP;
        CFD_IDX_BLKWP:   cfgRdData <= blkWpCell & CFD_MASK_BLKLO;
        CFD_IDX_BOOTWP:  cfgRdData <= bootWpCell & CFD_MASK_BOOTWP;
        CFD_IDX_BLKTRP:  cfgRdData <= blkTrpCell & CFD_MASK_BLKLO;
        CFD_IDX_BOOTTRP: cfgRdData <= bootTrpCell & CFD_MASK_BOOTTRP;
        default:         cfgRdData <= 8'h00;
      endcase
    end
    else
      cfgRdData <= 8'h00;
  end

  cfd_bormode_t borMode;
  logic [1:0]   borLvl;
  logic [3:0]   wdPs;
  logic [3:0]   rdMask;
  logic [3:0]   exMask;

  assign borMode = cfd_bormode_t'(borPwr_r[CFD_POS_BORMODE +: 2]);
  assign borLvl  = borPwr_r[CFD_POS_BORLVL +: 2];
  assign wdPs    = wdog_r[CFD_POS_WDPS +: 4];

  always_comb
  begin
    unique case (borLvl)
      2'b11: brownoutTripVoltage = CFD_MV_LVL3;
      2'b10: brownoutTripVoltage = CFD_MV_LVL2;
      2'b01: brownoutTripVoltage = CFD_MV_LVL1;
      2'b00: brownoutTripVoltage = CFD_MV_LVL0;
    endcase
  end

  always_comb
  begin
    unique case (borMode)
      CFD_BOR_ALWAYS:  brownoutResetEnable = 1'b1;
      CFD_BOR_NOSLEEP: brownoutResetEnable = !sleepActive;
      CFD_BOR_SOFT:    brownoutResetEnable = swBrownoutEnable;
      CFD_BOR_OFF:     brownoutResetEnable = 1'b0;
    endcase
  end

  // separate bit, no term shared with brown-out
  assign powerupDelayEnable     = !borPwr_r[CFD_POS_POWERUP_DELAY_TIMER];
  assign watchdogPostscaleRatio = 16'h0001 << wdPs;
  assign watchdogTimeoutMs      = 32'(CFD_WDOG_BASE_MS) * 32'(watchdogPostscaleRatio);
  assign watchdogEnable         = wdog_r[CFD_POS_WDEN] || watchdogSoftEnable;
  assign externalResetActive    = rstOsc_r[CFD_POS_RSTPIN] && !externalResetPin_n;
  assign sharedInputPin         = rstOsc_r[CFD_POS_RSTPIN] ? 1'b0 : externalResetPin_n;
  assign cpuClockEnable         = loaded_r
                                  && (rstOsc_r[CFD_POS_FASTOSC] || fastInternalOscStable);
  assign debuggerEnable         = DEBUG_SILICON && !dbgCpu_r[CFD_POS_DBGDIS];
  assign extendedCpuEnable      = dbgCpu_r[CFD_POS_EXTCPU];
  assign bootBlockWords         = LARGE_VARIANT
                                  ? (dbgCpu_r[CFD_POS_BOOTSZ] ? CFD_BOOT_2KW : CFD_BOOT_1KW)
                                  : (dbgCpu_r[CFD_POS_BOOTSZ] ? CFD_BOOT_1KW : CFD_BOOT_512W);
  assign lowVoltProgEnable      = dbgCpu_r[CFD_POS_LVP];
  assign stackFaultReset        = dbgCpu_r[CFD_POS_STKRST] && stackFault;
  // region order: 0 block0, 1 block1, 2 boot, 3 eeprom
  assign codeProtect    = ~{bootCp_r[7], bootCp_r[6], blkCp_r[1], blkCp_r[0]};
  assign selfWriteBlock = ~{bootWp_r[7], bootWp_r[6], blkWp_r[1], blkWp_r[0]};
  assign cfgWriteProtect = !bootWp_r[CFD_POS_CFGWP];
  // table read of region 3, or of a region (0..2) with its bit clear, from code in a different region
  assign rdMask = {1'b0, bootTrp_r[6], blkTrp_r[1], blkTrp_r[0]};
  assign exMask = 4'h1 << execBlock;
  assign tableReadReject = tableRead && (readBlock != execBlock)
                           && !rdMask[readBlock] && !exMask[readBlock];
endmodule

/* core/cfd_pkg.sv */
package cfd_pkg;
  // configuration byte addresses (documented map)
  localparam logic [21:0] CFD_BASE_ADDR     = 22'h300000;
  localparam logic [3:0]  CFD_IDX_BORPWR    = 4'h2;
  localparam logic [3:0]  CFD_IDX_WDOG      = 4'h3;
  localparam logic [3:0]  CFD_IDX_RSTOSC    = 4'h5;
  localparam logic [3:0]  CFD_IDX_DBGCPU    = 4'h6;
  localparam logic [3:0]  CFD_IDX_BLKCP     = 4'h8;
  localparam logic [3:0]  CFD_IDX_BOOTCP    = 4'h9;
  localparam logic [3:0]  CFD_IDX_BLKWP     = 4'ha;
  localparam logic [3:0]  CFD_IDX_BOOTWP    = 4'hb;
  localparam logic [3:0]  CFD_IDX_BLKTRP    = 4'hc;
  localparam logic [3:0]  CFD_IDX_BOOTTRP   = 4'hd;
  // implemented bit masks
  localparam logic [7:0]  CFD_MASK_BORPWR   = 8'h1f;
  localparam logic [7:0]  CFD_MASK_WDOG     = 8'h1f;
  localparam logic [7:0]  CFD_MASK_RSTOSC   = 8'h88;
  localparam logic [7:0]  CFD_MASK_DBGCPU   = 8'hcd;
  localparam logic [7:0]  CFD_MASK_BLKLO    = 8'h03;
  localparam logic [7:0]  CFD_MASK_BOOTCP   = 8'hc0;
  localparam logic [7:0]  CFD_MASK_BOOTWP   = 8'he0;
  localparam logic [7:0]  CFD_MASK_BOOTTRP  = 8'h40;
  // clear-only protection bits
  localparam logic [7:0]  CFD_CLRONLY_BOOTWP = 8'hc0;
  // unprogrammed values
  localparam logic [7:0]  CFD_RST_BORPWR    = 8'h1f;
  localparam logic [7:0]  CFD_RST_WDOG      = 8'h1f;
  localparam logic [7:0]  CFD_RST_RSTOSC    = 8'h88;
  localparam logic [7:0]  CFD_RST_DBGCPU    = 8'h85;
  localparam logic [7:0]  CFD_RST_BLKLO     = 8'h03;
  localparam logic [7:0]  CFD_RST_BOOTCP    = 8'hc0;
  localparam logic [7:0]  CFD_RST_BOOTWP    = 8'he0;
  localparam logic [7:0]  CFD_RST_BOOTTRP   = 8'h40;
  localparam logic [7:0]  CFD_DEBUG_BIT     = 8'h80;
  // field positions
  localparam int CFD_POS_POWERUP_DELAY_TIMER    = 0;
  localparam int CFD_POS_BORMODE = 1;
  localparam int CFD_POS_BORLVL  = 3;
  localparam int CFD_POS_WDEN    = 0;
  localparam int CFD_POS_WDPS    = 1;
  localparam int CFD_POS_FASTOSC = 3;
  localparam int CFD_POS_RSTPIN  = 7;
  localparam int CFD_POS_STKRST  = 0;
  localparam int CFD_POS_LVP     = 2;
  localparam int CFD_POS_BOOTSZ  = 3;
  localparam int CFD_POS_EXTCPU  = 6;
  localparam int CFD_POS_DBGDIS  = 7;
  localparam int CFD_POS_CFGWP   = 5;
  // trip voltages in millivolts, indexed by level code
  localparam logic [11:0] CFD_MV_LVL3 = 12'd1900;
  localparam logic [11:0] CFD_MV_LVL2 = 12'd2200;
  localparam logic [11:0] CFD_MV_LVL1 = 12'd2700;
  localparam logic [11:0] CFD_MV_LVL0 = 12'd3000;
  // watchdog base period
  localparam int CFD_WDOG_BASE_MS = 4;
  // boot block sizes in words
  localparam logic [11:0] CFD_BOOT_2KW  = 12'd2048;
  localparam logic [11:0] CFD_BOOT_1KW  = 12'd1024;
  localparam logic [11:0] CFD_BOOT_512W = 12'd512;
  typedef enum logic [1:0] {
    CFD_BOR_OFF,
    CFD_BOR_SOFT,
    CFD_BOR_NOSLEEP,
    CFD_BOR_ALWAYS
  } cfd_bormode_t;
endpackage

/* tb/cfd_fuse_decode_checker.sv */
`timescale 1ns/1ps
module cfd_fuse_decode_checker
  import cfd_pkg::*;
#(
  parameter bit DEBUG_SILICON = 1'b0
)
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        cfgRead,
  input wire logic [21:0] cfgAddr,
  input wire logic [7:0]  cfgRdData,
  input wire logic        watchdogSoftEnable,
  input wire logic        externalResetPin_n,
  input wire logic        fastInternalOscStable,
  input wire logic [1:0]  execBlock,
  input wire logic [1:0]  readBlock,
  input wire logic        tableRead,
  input wire logic [15:0] watchdogPostscaleRatio,
  input wire logic [31:0] watchdogTimeoutMs,
  input wire logic        watchdogEnable,
  input wire logic        externalResetActive,
  input wire logic        sharedInputPin,
  input wire logic        cpuClockEnable,
  input wire logic        debuggerEnable,
  input wire logic [3:0]  codeProtect,
  input wire logic [3:0]  selfWriteBlock,
  input wire logic        tableReadReject
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_idle;
    !cfgRead;
  endsequence
  sequence s_far;
    cfgRead && cfgAddr[21:4] != 18'h30000;
  endsequence
  chk_timeout_scale: assert property (watchdogTimeoutMs == 32'(watchdogPostscaleRatio) * 32'd4)
    else $error("watchdog timeout not four times ratio");
  chk_ratio_pow2: assert property ($onehot(watchdogPostscaleRatio))
    else $error("postscale ratio not a power of two");
  chk_soft_wdog: assert property (watchdogSoftEnable |-> watchdogEnable)
    else $error("soft watchdog enable ignored");
  chk_pin_reset: assert property (externalResetActive |-> !externalResetPin_n && !sharedInputPin)
    else $error("reset pin and input pin both active");
  chk_fast_clock: assert property ($past(reset_n) && fastInternalOscStable |-> cpuClockEnable)
    else $error("cpu clock held with stable oscillator");
  chk_no_debug: assert property (DEBUG_SILICON || !debuggerEnable)
    else $error("debugger enabled on plain silicon");
  chk_same_block: assert property (tableRead && execBlock == readBlock |-> !tableReadReject)
    else $error("own block table read rejected");
  chk_read_idle: assert property (s_idle |=> cfgRdData == 8'h00)
    else $error("read data without read");
  chk_far_zero: assert property (s_far |=> cfgRdData == 8'h00)
    else $error("unmapped byte read nonzero");
  chk_fields_hold: assert property ($past(reset_n) |-> $stable(codeProtect) && $stable(selfWriteBlock))
    else $error("decoded fields changed outside reset");
endmodule
bind cfd_fuse_decode cfd_fuse_decode_checker #(.DEBUG_SILICON(DEBUG_SILICON)) u_chk (
  .mclk, .reset_n, .cfgRead, .cfgAddr, .cfgRdData, .watchdogSoftEnable, .externalResetPin_n,
  .fastInternalOscStable, .execBlock, .readBlock, .tableRead, .watchdogPostscaleRatio,
  .watchdogTimeoutMs, .watchdogEnable, .externalResetActive, .sharedInputPin, .cpuClockEnable,
  .debuggerEnable, .codeProtect, .selfWriteBlock, .tableReadReject);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import cfd_pkg::*;
;
  logic        mclk = 1'b0, reset_n = 1'b0, progMode = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0;
  logic        swBrownoutEnable = 1'b0, sleepActive = 1'b1, watchdogSoftEnable = 1'b0;
  logic        externalResetPin_n = 1'b0, fastInternalOscStable = 1'b0, stackFault = 1'b1;
  logic        tableRead = 1'b1, externalResetActive, sharedInputPin, cpuClockEnable;
  logic [1:0]  execBlock = 2'h1, readBlock = 2'h0;
  logic [21:0] cfgAddr = 22'h0;
  logic [7:0]  cfgWrData = 8'h00, cfgRdData;
  logic [11:0] brownoutTripVoltage, bootBlockWords;
  logic [15:0] watchdogPostscaleRatio;
  logic [31:0] watchdogTimeoutMs;
  logic        brownoutResetEnable, powerupDelayEnable, watchdogEnable, debuggerEnable;
  logic        extendedCpuEnable, lowVoltProgEnable, stackFaultReset, cfgWriteProtect;
  logic        tableReadReject;
  logic [3:0]  codeProtect, selfWriteBlock;
  int          failures = 0, n_checks = 0;
  logic [7:0]  dflt [16] = '{8'h00, 8'h00, 8'h1f, 8'h1f, 8'h00, 8'h88, 8'h85, 8'h00,
                             8'h03, 8'hc0, 8'h03, 8'he0, 8'h03, 8'h40, 8'h00, 8'h00};
  logic [7:0]  wv [16] = '{8'hff, 8'hff, 8'h00, 8'h0a, 8'hff, 8'h00, 8'h48, 8'hff,
                           8'h02, 8'h40, 8'h01, 8'ha0, 8'h02, 8'hff, 8'hff, 8'hff};
  logic [7:0]  rv [16] = '{8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00, 8'hc8, 8'h00,
                           8'h02, 8'h40, 8'h01, 8'ha0, 8'h02, 8'h40, 8'h00, 8'h00};

  cfd_fuse_decode dut (
    .mclk, .reset_n, .progMode, .cfgWrite, .cfgAddr, .cfgWrData, .cfgRead, .cfgRdData,
    .swBrownoutEnable, .sleepActive, .watchdogSoftEnable, .externalResetPin_n,
    .fastInternalOscStable, .stackFault, .execBlock, .readBlock, .tableRead,
    .brownoutTripVoltage, .brownoutResetEnable, .powerupDelayEnable, .watchdogPostscaleRatio,
    .watchdogTimeoutMs, .watchdogEnable, .externalResetActive, .sharedInputPin,
    .cpuClockEnable, .debuggerEnable, .extendedCpuEnable, .bootBlockWords, .lowVoltProgEnable,
    .stackFaultReset, .codeProtect, .selfWriteBlock, .cfgWriteProtect, .tableReadReject);

  always #2.5 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cfg_wr(input logic [3:0] idx, input logic [7:0] d);
    cfgAddr = {18'h30000, idx};
    cfgWrData = d;
    cfgWrite = 1'b1;
    @(negedge mclk);
    cfgWrite = 1'b0;
    @(negedge mclk);
  endtask

  task automatic cfg_rd(input logic [21:0] a, input logic [7:0] exp);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge mclk);
    cfgRead = 1'b0;
    check(32'(cfgRdData), 32'(exp));
    @(negedge mclk);
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
  endtask

  task automatic stop_test();
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    stop_test();
  end

  initial
  begin
    @(negedge mclk);
    do_reset();
    for (int i = 2; i < 16; i++)
      cfg_rd({18'h30000, i[3:0]}, dflt[i]);
    cfg_rd(22'h200002, 8'h00);
    check(32'(brownoutTripVoltage), 32'd1900);
    check(32'(brownoutResetEnable), 32'd1);
    check(32'(powerupDelayEnable), 32'd0);
    check(32'(watchdogPostscaleRatio), 32'd32768);
    check(watchdogTimeoutMs, 32'd131072);
    check(32'(watchdogEnable), 32'd1);
    check(32'({externalResetActive, sharedInputPin}), 32'h2);
    check(32'(cpuClockEnable), 32'd1);
    check(32'({debuggerEnable, extendedCpuEnable, lowVoltProgEnable, stackFaultReset}), 32'h3);
    check(32'(bootBlockWords), 32'd1024);
    check(32'({codeProtect, selfWriteBlock, cfgWriteProtect, tableReadReject}), 32'h0);
    cfg_wr(4'hb, 8'hc0);
    cfg_rd(22'h30000b, 8'he0);
    progMode = 1'b1;
    for (int i = 2; i < 14; i++)
      cfg_wr(i[3:0], wv[i]);
    check(32'(codeProtect), 32'h0);
    cfg_wr(4'h8, 8'h03);
    for (int i = 2; i < 15; i++)
      cfg_rd({18'h30000, i[3:0]}, rv[i]);
    progMode = 1'b0;
    swBrownoutEnable = 1'b1;
    externalResetPin_n = 1'b1;
    do_reset();
    check(32'(brownoutTripVoltage), 32'd3000);
    check(32'({brownoutResetEnable, powerupDelayEnable}), 32'h1);
    check(32'(watchdogPostscaleRatio), 32'd32);
    check(watchdogTimeoutMs, 32'd128);
    check(32'({watchdogEnable, externalResetActive, sharedInputPin}), 32'h1);
    check(32'(cpuClockEnable), 32'd0);
    check(32'({debuggerEnable, extendedCpuEnable, lowVoltProgEnable, stackFaultReset}), 32'h4);
    check(32'(bootBlockWords), 32'd2048);
    check(32'({codeProtect, selfWriteBlock, tableReadReject}), 32'h12d);
    watchdogSoftEnable = 1'b1;
    fastInternalOscStable = 1'b1;
    execBlock = 2'h0;
    @(negedge mclk);
    check(32'({watchdogEnable, cpuClockEnable, tableReadReject}), 32'h6);
    for (int i = 1; i < 3; i++)
    begin
      progMode = 1'b1;
      cfg_wr(4'h2, {3'b000, i[1:0], i[1:0], 1'b1});
      progMode = 1'b0;
      do_reset();
      check(32'(brownoutTripVoltage), (i == 1) ? 32'd2700 : 32'd2200);
      for (int j = 0; j < 4; j++)
      begin
        {sleepActive, swBrownoutEnable} = j[1:0];
        @(negedge mclk);
        check(32'(brownoutResetEnable), (i == 1) ? 32'(j[0]) : 32'(!j[1]));
      end
    end
    progMode = 1'b1;
    cfg_wr(4'hb, 8'hc0);
    progMode = 1'b0;
    cfg_wr(4'h2, 8'h1f);
    cfg_rd(22'h300002, 8'h15);
    do_reset();
    check(32'(cfgWriteProtect), 32'd1);
    stop_test();
  end
endmodule
